/* File: dc_offset_autocal_test.sv */
// self-checking bench for the dc offset calibration block
// assumes dco_pkg, dco_autocal and dco_det_model compiled first
`timescale 1ns/10ps
module dc_offset_autocal_test;
	import dco_pkg::*;
	// ---------------
	// signals
	// ---------------
	logic        pclk, presetn, psel, penable, pwrite, serial_clk;
	logic [7:0]  paddr, tgt_i, tgt_q;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, det_i, det_q, rbyp, cbyp, busy;
	logic [1:0]  range;
	dco_codes_t  codes;
	int          bad_count = 0;
	int          compares = 0;
	int          cyc = 0;
	int          waits = 0;

	dco_autocal i_dco_autocal (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clk(serial_clk), .det_i_positive(det_i),
		.det_q_positive(det_q), .dac_codes(codes), .offset_dac_range_select(range),
		.detector_resistor_bypass(rbyp), .detector_capacitor_bypass(cbyp), .cal_busy(busy));
	dco_det_model i_dco_det_model (.pclk(pclk), .dac_codes(codes), .target_i(tgt_i),
		.target_q(tgt_q), .det_i_positive(det_i), .det_q_positive(det_q));

	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end

	// ---------------
	// helpers
	// ---------------
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		waits = 0;
		do begin
			@(posedge pclk);
			waits++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(string nm, logic [7:0] a, logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd);
	endtask

	// let registered outputs land
	task automatic settle();
		repeat (2) @(negedge pclk);
	endtask

	// serial clock pulsed n times, whether or not a calibration is running; half is pclk cycles per level
	task automatic sclk_pulses(int n, int half);
		@(posedge pclk);
		repeat (n) begin
			serial_clk <= 1'b1;
			repeat (half) @(posedge pclk);
			serial_clk <= 1'b0;
			repeat (half) @(posedge pclk);
		end
	endtask

	// ---------------
	// scenarios
	// ---------------
	task automatic test_reset();
		settle();
		chk("codes", 32'h0000_8080, {16'h0000, codes});
		rdchk("readback", ADDR_READBACK, 32'h8080_0000);
		rdchk("ctrl2", ADDR_CTRL2, 32'h7100_0000);
	endtask

	task automatic test_fields();
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, ADDR_CTRL2, 32'h7100_0000 | (r << 22));
			apb(1'b1, ADDR_CTRL1, r << 25);
			settle();
			chk("range", 32'(r), {30'h0, range});
			chk("bypass", 32'(r), {30'h0, cbyp, rbyp});
			rdchk("ctrl1", ADDR_CTRL1, r << 25);
		end
	endtask

	task automatic test_errors();
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("wait states", 32'h1, waits);
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, ADDR_READBACK, 32'h0000_0000);
		chk("ro err", 32'h1, {31'h0, err});
		rdchk("ro kept", ADDR_READBACK, 32'h8080_0000);
	endtask

	task automatic test_sclk_cal();
		apb(1'b1, ADDR_CTRL2, 32'h6100_0020);
		sclk_pulses(8, 4);
		rdchk("running", ADDR_CTRL2, 32'h6100_0020);
		sclk_pulses(1, 4);
		rdchk("self clear", ADDR_CTRL2, 32'h6100_0000);
		chk("cal codes", 32'h5AC3, {16'h0, codes});
		rdchk("readback", ADDR_READBACK, 32'h5AC3_0000);
		tgt_i <= 8'h10;
		sclk_pulses(2, 4);
		chk("held", 32'h5AC3, {16'h0, codes});
	endtask

	// oscillator clocked run, duration against nine divided periods
	task automatic test_osc(int t, int dv);
		int n;
		int p;
		p = CLK_KHZ / OSC_KHZ[t] * (1 << DIV_LOG2[dv]);
		n = 0;
		apb(1'b1, ADDR_CTRL2, (t << 29) | 32'h1100_0020 | (dv << 25));
		repeat (3) @(negedge pclk);
		chk("busy", 32'h1, {31'h0, busy});
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge pclk);
			n++;
		end
		chk("duration", 32'h1, {31'h0, n >= 8 * p - 3 && n <= 9 * p + 3});
		settle();
		chk("osc codes", 32'h10C3, {16'h0, codes});
	endtask

	task automatic test_manual();
		apb(1'b1, ADDR_MANUAL, 32'h0000_1234);
		apb(1'b1, ADDR_CTRL2, 32'h7000_0000);
		settle();
		chk("manual", 32'h1234, {16'h0, codes});
		rdchk("manual rb", ADDR_READBACK, 32'h1234_0000);
		apb(1'b1, ADDR_CTRL2, 32'h7100_0000);
		settle();
		chk("auto back", 32'h10C3, {16'h0, codes});
	endtask

	// reset in mid calibration returns everything to its start values
	task automatic test_midreset();
		apb(1'b1, ADDR_CTRL2, 32'h6100_0020);
		sclk_pulses(3, 4);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk("reset busy", 32'h0, {31'h0, busy});
		chk("reset codes", 32'h8080, {16'h0, codes});
		rdchk("reset ctrl2", ADDR_CTRL2, 32'h7100_0000);
	endtask

	// slow run: narrowed detector filter, divide by 1024, fast serial clock
	task automatic test_slow_cal();
		tgt_i <= 8'hA7;
		tgt_q <= 8'h3C;
		apb(1'b1, ADDR_CTRL1, 32'h0000_0000);
		apb(1'b1, ADDR_CTRL2, 32'h6F00_0020);
		sclk_pulses(9 * 1024 - 1, 1);
		settle();
		chk("slow running", 32'h1, {31'h0, busy});
		sclk_pulses(1, 1);
		settle();
		chk("slow done", 32'h0, {31'h0, busy});
		chk("slow codes", 32'hA73C, {16'h0, codes});
	endtask

	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		serial_clk = 1'b0;
		tgt_i = 8'h5A;
		tgt_q = 8'hC3;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_fields();
		test_errors();
		test_sclk_cal();
		test_osc(7, 1);
		test_osc(0, 0);
		test_osc(3, 3);
		test_manual();
		test_midreset();
		test_slow_cal();
		final_report();
	end
endmodule

/* File: dco_autocal.sv */
// dc offset calibration control: apb registers, calibration clock, engine
// assumes detector comparator outputs and serial clock synchronous to pclk
// Functional notes
// R01 - oscillator clocks engine when select set
// R02 - trim code picks oscillator frequency
// R03 - trim resets to 900 kHz code
// R04 - range field sets dac full scale
// R05 - auto source bit uses internal codes
// R06 - internal codes start at half scale
// R07 - writing start bit launches calibration
// R08 - start bit clears itself when done
// R09 - system keeps lo applied during calibration
// R10 - codes held until next calibration
// R11 - two bits bypass detector filter parts
// R12 - divider field slows calibration clock
// R13 - calibration lasts nine divided clocks
// R14 - host picks divide 1024 with signal
// R15 - manual mode drives host written codes
// R16 - host measures offset, writes both codes
// R17 - readback gives q and i codes
// R18 - one code step per divided clock

`timescale 1ns/10ps

module dco_autocal
	import dco_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// calibration clock and detector
	input  wire logic        serial_clk,
	input  wire logic        det_i_positive,
	input  wire logic        det_q_positive,
	// analog controls and calibration busy status
	output dco_codes_t       dac_codes,
	output logic      [1:0]  offset_dac_range_select,
	output logic             detector_resistor_bypass,
	output logic             detector_capacitor_bypass,
	output logic             cal_busy
);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// -------------------------------------------------
	// declarations
	// -------------------------------------------------
	dco_ctrl2_t  ctrl2;      // calibration configuration
	dco_codes_t  manual;     // host written codes
	dco_codes_t  cal_codes;  // internal calibration codes
	dco_state_t  state;      // engine state
	logic [3:0]  step_cnt;   // divided clocks seen
	logic [7:0]  trial;      // bit under test
	logic [15:0] osc_cnt;    // oscillator phase
	logic [15:0] osc_div;    // pclk cycles per oscillator period
	logic        osc_tick;   // oscillator period pulse
	logic        sclk_q;     // serial clock, one cycle late
	logic        sclk_rise;  // serial clock rising edge
	logic        cal_tick;   // selected calibration clock pulse
	logic [9:0]  div_cnt;    // divider phase
	logic [9:0]  div_max;    // divider ratio minus one
	logic        div_tick;   // divided clock pulse
	logic        cal_done;   // last step pulse
	logic        wr_en;      // apb write access
	logic        addr_ok;    // address is mapped
	logic [31:0] rd_word;    // read mux
	logic        start_wr;   // host writes start bit high

	// -------------------------------------------------
	// apb decode
	// -------------------------------------------------
	assign wr_en    = psel & penable & pwrite;
	assign pready   = 1'b1;
	assign start_wr = wr_en & (paddr == ADDR_CTRL2) & pwdata[START_BIT]; // R07

	// read mux and address check
	always_comb begin
		addr_ok = 1'b1;
		rd_word = 32'h0000_0000;
		if (paddr == ADDR_READBACK) begin
			rd_word[31:16] = dac_codes; // R17
		end else if (paddr == ADDR_CTRL1) begin
			rd_word[BYP_RES_BIT] = detector_resistor_bypass;
			rd_word[BYP_CAP_BIT] = detector_capacitor_bypass;
		end else if (paddr == ADDR_CTRL2) begin
			rd_word = ctrl2;
		end else if (paddr == ADDR_MANUAL) begin
			rd_word[15:0] = manual;
		end else begin
			addr_ok = 1'b0; // unmapped reads zero
		end
	end

	// error on unmapped access or write to readback
	assign pslverr = psel & penable & (~addr_ok | (pwrite & (paddr == ADDR_READBACK)));

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= rd_word;
		end
	end

	// -------------------------------------------------
	// configuration registers
	// -------------------------------------------------
	// detector filter bypass bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detector_resistor_bypass  <= 1'b0;
			detector_capacitor_bypass <= 1'b0;
		end else if (wr_en & (paddr == ADDR_CTRL1)) begin
			detector_resistor_bypass  <= pwdata[BYP_RES_BIT]; // R11
			detector_capacitor_bypass <= pwdata[BYP_CAP_BIT]; // R11
		end
	end

	// control 2; start is set by host, cleared by engine, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl2 <= CTRL2_RESET; // R03
		end else begin
			if (wr_en & (paddr == ADDR_CTRL2)) begin
				ctrl2.osc_trim                <= pwdata[31:29];
				ctrl2.clk_sel                 <= pwdata[28];
				ctrl2.div_sel                 <= pwdata[27:25];
				ctrl2.auto_src                <= pwdata[24];
				ctrl2.offset_dac_range_select <= pwdata[23:22];
			end
			if (start_wr) begin
				ctrl2.calibration_start_selfclear <= 1'b1; // R07
			end else if (cal_done) begin
				ctrl2.calibration_start_selfclear <= 1'b0; // R08
			end
		end
	end

	assign offset_dac_range_select = ctrl2.offset_dac_range_select; // R04

	// host written codes for manual mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			manual <= {HALF_SCALE, HALF_SCALE};
		end else if (wr_en & (paddr == ADDR_MANUAL)) begin
			manual <= pwdata[15:0];
		end
	end

	// -------------------------------------------------
	// calibration clock
	// -------------------------------------------------
	// oscillator period from trim code
	always_comb begin
		osc_div = 16'h0001;
		for (int k = 0; k < 8; k++) begin
			if (ctrl2.osc_trim == 3'(k)) begin
				osc_div = 16'(CLK_KHZ / OSC_KHZ[k]); // R02
			end
		end
	end

	assign osc_tick = (osc_cnt >= osc_div - 16'h0001);

	// free running oscillator counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt <= 16'h0000;
		end else if (osc_tick) begin
			osc_cnt <= 16'h0000;
		end else begin
			osc_cnt <= osc_cnt + 16'h0001;
		end
	end

	// serial clock edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= serial_clk;
		end
	end

	assign sclk_rise = serial_clk & ~sclk_q;
	assign cal_tick  = ctrl2.clk_sel ? osc_tick : sclk_rise; // R01

	// divider ratio from divider code
	always_comb begin
		div_max = 10'h000;
		for (int k = 0; k < 8; k++) begin
			if (ctrl2.div_sel == 3'(k)) begin
				div_max = 10'((1 << DIV_LOG2[k]) - 1); // R12
			end
		end
	end

	assign div_tick = (state == CAL_RUN) & cal_tick & (div_cnt >= div_max);

	// divider counter, restarted by each calibration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 10'h000;
		end else if (state == CAL_IDLE || div_tick) begin
			div_cnt <= 10'h000;
		end else if (cal_tick) begin
			div_cnt <= div_cnt + 10'h001; // R12
		end
	end

	// -------------------------------------------------
	// calibration engine
	// -------------------------------------------------
	assign cal_done = div_tick & (step_cnt == CAL_CYCLES - 4'h1); // R13
	assign cal_busy = (state == CAL_RUN);

	// state and step count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= CAL_IDLE;
			step_cnt <= 4'h0;
		end else begin
			case (state)
				CAL_IDLE: begin
					step_cnt <= 4'h0;
					if (ctrl2.calibration_start_selfclear) begin
						state <= CAL_RUN; // R07
					end
				end
				CAL_RUN: begin
					if (cal_done) begin
						state <= CAL_IDLE; // R13
					end else if (div_tick) begin
						step_cnt <= step_cnt + 4'h1;
					end
				end
				default: state <= CAL_IDLE;
			endcase
		end
	end

	// successive approximation; codes change only while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_codes <= {HALF_SCALE, HALF_SCALE}; // R06
			trial     <= HALF_SCALE;
		end else if (div_tick) begin
			if (step_cnt == 4'h0) begin
				cal_codes <= {HALF_SCALE, HALF_SCALE}; // R06
				trial     <= HALF_SCALE;
			end else begin
				// positive offset drops the bit under test, then try next
				cal_codes.i_channel_offset_code <= (det_i_positive ?
					(cal_codes.i_channel_offset_code & ~trial) :
					cal_codes.i_channel_offset_code) | (trial >> 1); // R18
				cal_codes.q_channel_offset_code <= (det_q_positive ?
					(cal_codes.q_channel_offset_code & ~trial) :
					cal_codes.q_channel_offset_code) | (trial >> 1); // R18
				trial <= trial >> 1;
			end
		end
	end

	// dac code source: internal or host written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_codes <= {HALF_SCALE, HALF_SCALE};
		end else if (ctrl2.auto_src) begin
			dac_codes <= cal_codes; // R05 R10
		end else begin
			dac_codes <= manual; // R15
		end
	end

	// -------------------------------------------------
	// assertions
	// -------------------------------------------------
	start_selfclear_a: assert property (cal_done && !start_wr |=> !ctrl2.calibration_start_selfclear) // R08
		else $error("start bit not cleared after calibration");
	start_launch_a: assert property (start_wr && state == CAL_IDLE |=> ##1 state == CAL_RUN) // R07
		else $error("calibration did not begin after start");
	half_scale_a: assert property (div_tick && step_cnt == 4'h0 |=> cal_codes == {HALF_SCALE, HALF_SCALE}) // R06
		else $error("calibration did not start at half scale");
	codes_hold_a: assert property (state == CAL_IDLE |=> $stable(cal_codes)) // R10
		else $error("codes changed outside calibration");
	src_select_a: assert property (1'b1 |=> // R05
		dac_codes == ($past(ctrl2.auto_src) ? $past(cal_codes) : $past(manual)))
		else $error("dac codes from wrong source");
	ext_clock_a: assert property (!ctrl2.clk_sel && !serial_clk ##1 !ctrl2.clk_sel && serial_clk |-> cal_tick) // R01
		else $error("serial clock edge not used");
	osc_gap_a: assert property (osc_tick |-> ##1 (!osc_tick || $changed(ctrl2.osc_trim))[*8]) // R02
		else $error("oscillator period too short");
	step_update_a: assert property (div_tick && step_cnt != 4'h0 && det_i_positive // R18
		|=> (cal_codes.i_channel_offset_code & $past(trial)) == 8'h00)
		else $error("tested bit not dropped on positive offset");
	nine_steps_a: assert property ($fell(cal_busy) |-> $past(div_tick) && $past(step_cnt) == CAL_CYCLES - 4'h1) // R13
		else $error("calibration length not nine clocks");
	readback_a: assert property (psel && !penable && !pwrite && paddr == ADDR_READBACK // R17
		|=> prdata == {$past(dac_codes), 16'h0000})
		else $error("readback word wrong");
	filter_byp_a: assert property (wr_en && paddr == ADDR_CTRL1 // R11
		|=> detector_resistor_bypass == $past(pwdata[BYP_RES_BIT])
		&& detector_capacitor_bypass == $past(pwdata[BYP_CAP_BIT]))
		else $error("filter bypass bits not stored");
	range_a: assert property (wr_en && paddr == ADDR_CTRL2 |=> offset_dac_range_select == $past(pwdata[23:22])) // R04
		else $error("dac range not stored");

endmodule

/* File: dco_det_model.sv */
// detector model facing the offset dacs of the calibration block
// assumes dac_codes from the block and targets set by the bench
`timescale 1ns/10ps
module dco_det_model
	import dco_pkg::*;
(
	// clock
	input  wire logic       pclk,
	// driven codes and cancelling targets
	input  wire dco_codes_t dac_codes,
	input  wire logic [7:0] target_i,
	input  wire logic [7:0] target_q,
	// comparator outputs
	output logic            det_i_positive,
	output logic            det_q_positive
);
	// lo held for the whole run, so the detector is always live
	// a code above the target leaves a positive offset
	always_ff @(posedge pclk) begin
		det_i_positive <= dac_codes.i_channel_offset_code > target_i;
		det_q_positive <= dac_codes.q_channel_offset_code > target_q;
	end
endmodule

/* File: dco_pkg.sv */
// constants, register layouts and types for the dc offset calibration block
// assumes a single pclk domain at the rate given by CLK_KHZ

package dco_pkg;

	// -------------------------------------------------
	// clock and timing
	// -------------------------------------------------
	localparam int CLK_KHZ = 25000; // pclk rate in kHz (40 ns period)
	// oscillator frequency per trim code, kHz
	localparam int OSC_KHZ [8] = '{300, 500, 700, 900, 1100, 1300, 1500, 1800};
	// divider ratio per divider code, as a power of two
	localparam int DIV_LOG2 [8] = '{0, 1, 2, 4, 6, 8, 9, 10};
	localparam logic [3:0] CAL_CYCLES = 4'h9; // divided clocks per calibration

	// -------------------------------------------------
	// register byte offsets
	// -------------------------------------------------
	localparam logic [7:0] ADDR_READBACK = 8'h00;
	localparam logic [7:0] ADDR_CTRL1    = 8'h04;
	localparam logic [7:0] ADDR_CTRL2    = 8'h08;
	localparam logic [7:0] ADDR_MANUAL   = 8'h0C;

	// -------------------------------------------------
	// field positions and reset values
	// -------------------------------------------------
	localparam int BYP_RES_BIT = 25; // control 1: resistor bypass
	localparam int BYP_CAP_BIT = 26; // control 1: capacitor bypass
	localparam int START_BIT   = 5;  // control 2: start bit
	localparam logic [7:0] HALF_SCALE = 8'h80; // code 128
	localparam logic [2:0] TRIM_RESET = 3'h3;  // 900 kHz

	// control 2 layout, msb first
	typedef struct packed {
		logic [2:0]  osc_trim;
		logic        clk_sel;
		logic [2:0]  div_sel;
		logic        auto_src;
		logic [1:0]  offset_dac_range_select;
		logic [15:0] rsvd_hi;
		logic        calibration_start_selfclear;
		logic [4:0]  rsvd_lo;
	} dco_ctrl2_t;

	localparam dco_ctrl2_t CTRL2_RESET = '{
		osc_trim: TRIM_RESET, clk_sel: 1'b1, div_sel: 3'h0, auto_src: 1'b1,
		offset_dac_range_select: 2'h0, rsvd_hi: 16'h0000,
		calibration_start_selfclear: 1'b0, rsvd_lo: 5'h00};

	// pair of offset codes, i in the upper byte
	typedef struct packed {
		logic [7:0] i_channel_offset_code;
		logic [7:0] q_channel_offset_code;
	} dco_codes_t;

	typedef enum logic {CAL_IDLE, CAL_RUN} dco_state_t;

endpackage
